// >>> core/tscc_top.sv
// Conversion control, calibration registers and two-wire register access of the sensor.
`timescale 1ns/1ns
// What this block does
// - Alert mask bit 7 set disables the alert output; clear enables it.
// - Mask only matters when the multifunction pin acts as alert.
// - With halt bit 6 clear, convert continuously at the programmed rate.
// - Setting halt finishes the running conversion, then stops; clearing resumes.
// - In shutdown a write to 0Fh runs one conversion; data is dropped.
// - Bit 5 picks alert (0) or second over-temperature output (1).
// - Bit 2 selects standard or extended measurement range.
// - Rate sets only idle time; read at 04h, written at 0Ah.
// - Codes 00h to 09h give 16 s down to 0.03125 s intervals.
// - Rate register resets to 08h, sixteen conversions per second.
// - Ideality correction is an 8-bit signed value, -128 to 127.
// - Ideality correction is read and written at 23h, resets to 00h.
// - Offset value is added to every remote channel result.
// - General call acknowledged; second byte 06h resets registers, aborts conversion.
// - Any other general call second byte does nothing.
// - Reading pointer FEh returns the fixed maker identification byte.
// - First write byte loads the pointer; reads use the pointer.
module tscc_top #(
    parameter int RATE_MIN_CYCLES_P = tscc_pkg::RATE_MIN_CYCLES,
    parameter int CONV_CYCLES_P = tscc_pkg::CONV_CYCLES,
    parameter logic [6:0] DEV_ADDR = tscc_pkg::DEV_ADDR_DEFAULT,
    parameter logic [7:0] MAKER_ID = tscc_pkg::MAKER_ID_DEFAULT
) (
    input wire logic sys_clk_i, // System clock, 50 MHz.
    input wire logic rst_n_i, // Asynchronous reset, active low.
    input wire logic scl_i, // Two-wire bus clock pin.
    input wire logic sda_i, // Two-wire bus data pin level.
    output logic sda_o, // Data pin drive value, always low.
    output logic sda_oe_n_o, // Data pin enable, low pulls the line low.
    input wire logic alert_flag_i, // Alert latch from the comparators.
    input wire logic second_overtemp_flag_i, // High-limit event for the second output.
    input wire logic [11:0] local_raw_i, // Local channel raw result.
    input wire logic [11:0] remote_raw_i, // Remote channel raw result.
    input wire logic [7:0] remote_offset_trim_i, // Remote offset, result high-byte format.
    output logic multi_out_n_o, // Multifunction output pin, active low.
    output logic conv_start_o, // Pulse that starts a two-channel conversion.
    output logic busy_o, // High while converting.
    output logic result_valid_o, // Pulse when results are updated.
    output logic [11:0] local_result_o, // Latched local result.
    output logic [11:0] remote_result_o, // Latched remote result with offset.
    output logic range_ext_o, // Extended range selected.
    output logic [7:0] ideality_adj_o // Signed ideality correction value.
);
    import tscc_pkg::*;

    function automatic logic [7:0] reg_read(input logic [7:0] ptr, input tscc_cfg_type cfg,
                                            input logic [7:0] rate, input logic [7:0] ideal);
        logic [7:0] val;
        val = READ_NONE;
        case (ptr)
            PTR_CFG_RD: val = cfg;
            PTR_RATE_RD: val = rate;
            PTR_IDEAL: val = ideal;
            PTR_MAKER: val = MAKER_ID;
            default: val = READ_NONE;
        endcase
        return val;
    endfunction : reg_read

    function automatic logic [31:0] conv_period(input logic [7:0] rate);
        logic [7:0] code;
        code = (rate > RATE_MAX_CODE) ? RATE_MAX_CODE : rate;
        return 32'(RATE_MIN_CYCLES_P) << (RATE_MAX_CODE - code);
    endfunction : conv_period

    logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
    logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
    logic scl_rise, scl_fall, bus_start, bus_stop;

    tscc_bus_type bus_state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] rx_reg;
    logic [7:0] tx_reg;
    logic sda_oe_n_reg;
    logic rw_reg;
    logic gc_reg;
    logic first_byte_reg;
    logic nack_reg;
    logic ptr_load_reg;
    logic reg_wr_reg;
    logic gc_rst_reg;
    logic [7:0] rd_data;

    logic [7:0] ptr_reg;
    tscc_cfg_type cfg_reg;
    logic [7:0] rate_reg;
    logic [7:0] ideal_reg;
    logic oneshot_reg;

    tscc_conv_type conv_state_reg;
    logic [31:0] conv_cnt_reg;
    logic [31:0] per_cnt_reg;
    logic [31:0] period_m1;
    logic conv_start_reg;
    logic busy_reg;
    logic valid_reg;
    logic [11:0] local_res_reg;
    logic [11:0] remote_res_reg;
    logic multi_out_n_reg;
    logic range_ext_reg;
    logic [7:0] ideal_out_reg;

    // Pin synchronisers; only the second stage and later are looked at.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_meta_reg <= scl_i;
            scl_sync_reg <= scl_meta_reg;
            scl_prev_reg <= scl_sync_reg;
            sda_meta_reg <= sda_i;
            sda_sync_reg <= sda_meta_reg;
            sda_prev_reg <= sda_sync_reg;
        end
    end

    assign scl_rise = scl_sync_reg & ~scl_prev_reg;
    assign scl_fall = ~scl_sync_reg & scl_prev_reg;
    assign bus_start = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
    assign bus_stop = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;
    assign rd_data = reg_read(ptr_reg, cfg_reg, rate_reg, ideal_reg);
    assign period_m1 = conv_period(rate_reg) - 32'h1;

    // Two-wire slave: bits taken on clock rise, data pin changed after clock fall.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_state_reg <= BS_IDLE;
            bit_cnt_reg <= 4'h0;
            rx_reg <= 8'h00;
            tx_reg <= 8'h00;
            sda_oe_n_reg <= 1'b1;
            rw_reg <= 1'b0;
            gc_reg <= 1'b0;
            first_byte_reg <= 1'b0;
            nack_reg <= 1'b0;
            ptr_load_reg <= 1'b0;
            reg_wr_reg <= 1'b0;
            gc_rst_reg <= 1'b0;
        end else begin
            ptr_load_reg <= 1'b0;
            reg_wr_reg <= 1'b0;
            gc_rst_reg <= 1'b0;
            if (bus_start) begin
                bus_state_reg <= BS_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_oe_n_reg <= 1'b1;
            end else if (bus_stop) begin
                bus_state_reg <= BS_IDLE;
                sda_oe_n_reg <= 1'b1;
            end else if (scl_rise) begin
                unique case (bus_state_reg)
                    BS_ADDR, BS_WDATA: begin
                        rx_reg <= {rx_reg[6:0], sda_sync_reg};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    BS_RDATA: bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    BS_RACK: nack_reg <= sda_sync_reg;
                    BS_IDLE, BS_AACK, BS_WACK: begin
                    end
                    default: bus_state_reg <= BS_IDLE;
                endcase
            end else if (scl_fall) begin
                unique case (bus_state_reg)
                    BS_ADDR: begin
                        if (bit_cnt_reg == BYTE_BITS) begin
                            if (rx_reg[7:1] == DEV_ADDR ||
                                (rx_reg[7:1] == GC_ADDR && !rx_reg[0])) begin
                                sda_oe_n_reg <= 1'b0;
                                bus_state_reg <= BS_AACK;
                                rw_reg <= rx_reg[0];
                                gc_reg <= (rx_reg[7:1] == GC_ADDR);
                                first_byte_reg <= 1'b1;
                            end else begin
                                bus_state_reg <= BS_IDLE;
                            end
                        end
                    end
                    BS_AACK: begin
                        bit_cnt_reg <= 4'h0;
                        if (rw_reg) begin
                            tx_reg <= rd_data;
                            sda_oe_n_reg <= rd_data[7];
                            bus_state_reg <= BS_RDATA;
                        end else begin
                            sda_oe_n_reg <= 1'b1;
                            bus_state_reg <= BS_WDATA;
                        end
                    end
                    BS_WDATA: begin
                        if (bit_cnt_reg == BYTE_BITS) begin
                            sda_oe_n_reg <= 1'b0;
                            bus_state_reg <= BS_WACK;
                            first_byte_reg <= 1'b0;
                            if (gc_reg) begin
                                gc_rst_reg <= first_byte_reg && (rx_reg == GC_RESET_CODE);
                            end else if (first_byte_reg) begin
                                ptr_load_reg <= 1'b1;
                            end else begin
                                reg_wr_reg <= 1'b1;
                            end
                        end
                    end
                    BS_WACK: begin
                        sda_oe_n_reg <= 1'b1;
                        bit_cnt_reg <= 4'h0;
                        bus_state_reg <= BS_WDATA;
                    end
                    BS_RDATA: begin
                        if (bit_cnt_reg == BYTE_BITS) begin
                            sda_oe_n_reg <= 1'b1;
                            bus_state_reg <= BS_RACK;
                        end else begin
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            sda_oe_n_reg <= tx_reg[6];
                        end
                    end
                    BS_RACK: begin
                        if (nack_reg) begin
                            bus_state_reg <= BS_IDLE;
                        end else begin
                            tx_reg <= rd_data;
                            sda_oe_n_reg <= rd_data[7];
                            bit_cnt_reg <= 4'h0;
                            bus_state_reg <= BS_RDATA;
                        end
                    end
                    BS_IDLE: begin
                    end
                    default: bus_state_reg <= BS_IDLE;
                endcase
            end
        end
    end

    // Register file; the general call reset returns it to power-on values.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr_reg <= PTR_RESET;
            cfg_reg <= CFG_RESET;
            rate_reg <= RATE_RESET;
            ideal_reg <= IDEAL_RESET;
            oneshot_reg <= 1'b0;
        end else if (gc_rst_reg) begin
            ptr_reg <= PTR_RESET;
            cfg_reg <= CFG_RESET;
            rate_reg <= RATE_RESET;
            ideal_reg <= IDEAL_RESET;
            oneshot_reg <= 1'b0;
        end else begin
            oneshot_reg <= 1'b0;
            if (ptr_load_reg) begin
                ptr_reg <= rx_reg;
            end
            if (reg_wr_reg) begin
                case (ptr_reg)
                    PTR_CFG_WR: cfg_reg <= rx_reg & CFG_WR_MASK;
                    PTR_RATE_WR: rate_reg <= rx_reg;
                    PTR_IDEAL: ideal_reg <= rx_reg;
                    PTR_ONESHOT: oneshot_reg <= cfg_reg.measurement_halt_bit;
                    default: oneshot_reg <= 1'b0;
                endcase
            end
        end
    end

    // Conversion scheduler; the period runs from each start, so the rate only moves idle time.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            conv_state_reg <= CV_HALT;
            conv_cnt_reg <= 32'h0;
            per_cnt_reg <= 32'h0;
            conv_start_reg <= 1'b0;
            busy_reg <= 1'b0;
            valid_reg <= 1'b0;
            local_res_reg <= 12'h000;
            remote_res_reg <= 12'h000;
        end else if (gc_rst_reg) begin
            conv_state_reg <= CV_HALT;
            conv_cnt_reg <= 32'h0;
            per_cnt_reg <= 32'h0;
            conv_start_reg <= 1'b0;
            busy_reg <= 1'b0;
            valid_reg <= 1'b0;
            local_res_reg <= 12'h000;
            remote_res_reg <= 12'h000;
        end else begin
            conv_start_reg <= 1'b0;
            valid_reg <= 1'b0;
            per_cnt_reg <= per_cnt_reg + 32'h1;
            unique case (conv_state_reg)
                CV_HALT: begin
                    if (!cfg_reg.measurement_halt_bit || oneshot_reg) begin
                        conv_state_reg <= CV_RUN;
                        conv_cnt_reg <= 32'h0;
                        per_cnt_reg <= 32'h0;
                        conv_start_reg <= 1'b1;
                        busy_reg <= 1'b1;
                    end
                end
                CV_RUN: begin
                    conv_cnt_reg <= conv_cnt_reg + 32'h1;
                    if (conv_cnt_reg == 32'(CONV_CYCLES_P) - 32'h1) begin
                        busy_reg <= 1'b0;
                        valid_reg <= 1'b1;
                        local_res_reg <= local_raw_i;
                        remote_res_reg <= remote_raw_i + {remote_offset_trim_i, OFFSET_FRAC};
                        conv_state_reg <= cfg_reg.measurement_halt_bit ? CV_HALT : CV_IDLE;
                    end
                end
                CV_IDLE: begin
                    if (cfg_reg.measurement_halt_bit) begin
                        conv_state_reg <= CV_HALT;
                    end else if (per_cnt_reg >= period_m1) begin
                        conv_state_reg <= CV_RUN;
                        conv_cnt_reg <= 32'h0;
                        per_cnt_reg <= 32'h0;
                        conv_start_reg <= 1'b1;
                        busy_reg <= 1'b1;
                    end
                end
                default: conv_state_reg <= CV_HALT;
            endcase
        end
    end

    // Multifunction pin and configuration outputs.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            multi_out_n_reg <= 1'b1;
            range_ext_reg <= 1'b0;
            ideal_out_reg <= IDEAL_RESET;
        end else begin
            if (cfg_reg.multifunction_output_select) begin
                multi_out_n_reg <= ~second_overtemp_flag_i;
            end else begin
                multi_out_n_reg <= ~(alert_flag_i & ~cfg_reg.alert_mask_bit);
            end
            range_ext_reg <= cfg_reg.range_ext;
            ideal_out_reg <= ideal_reg;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_n_o = sda_oe_n_reg;
    assign multi_out_n_o = multi_out_n_reg;
    assign conv_start_o = conv_start_reg;
    assign busy_o = busy_reg;
    assign result_valid_o = valid_reg;
    assign local_result_o = local_res_reg;
    assign remote_result_o = remote_res_reg;
    assign range_ext_o = range_ext_reg;
    assign ideality_adj_o = ideal_out_reg;

endmodule : tscc_top

// >>> include/tscc_pkg.sv
// Constants, register map and types shared by the temperature sensor conversion control.
package tscc_pkg;

    // Timing figures in their own units and the derived cycle counts.
    localparam int CLK_PERIOD_NS = 20;
    localparam int RATE_MIN_PERIOD_NS = 31250000;
    localparam int RATE_MIN_CYCLES = RATE_MIN_PERIOD_NS / CLK_PERIOD_NS;
    localparam int CONV_TIME_NS = 12000000;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;

    // Pointer addresses.
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] PTR_CFG_RD = 8'h03;
    localparam logic [7:0] PTR_RATE_RD = 8'h04;
    localparam logic [7:0] PTR_CFG_WR = 8'h09;
    localparam logic [7:0] PTR_RATE_WR = 8'h0A;
    localparam logic [7:0] PTR_ONESHOT = 8'h0F;
    localparam logic [7:0] PTR_IDEAL = 8'h23;
    localparam logic [7:0] PTR_MAKER = 8'hFE;

    // Reset values and field masks.
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_WR_MASK = 8'hE4;
    localparam logic [7:0] RATE_RESET = 8'h08;
    localparam logic [7:0] RATE_MAX_CODE = 8'h09;
    localparam logic [7:0] IDEAL_RESET = 8'h00;
    localparam logic [7:0] READ_NONE = 8'h00;
    localparam logic [3:0] OFFSET_FRAC = 4'h0;

    // Two-wire bus constants.
    localparam logic [6:0] GC_ADDR = 7'h00;
    localparam logic [7:0] GC_RESET_CODE = 8'h06;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h4C;
    // Arbitrary identification value.
    localparam logic [7:0] MAKER_ID_DEFAULT = 8'hA5;

    typedef struct packed {
        logic alert_mask_bit;
        logic measurement_halt_bit;
        logic multifunction_output_select;
        logic [1:0] rsv_hi;
        logic range_ext;
        logic [1:0] rsv_lo;
    } tscc_cfg_type;

    typedef enum logic [1:0] {
        CV_HALT = 2'b00,
        CV_RUN = 2'b01,
        CV_IDLE = 2'b10
    } tscc_conv_type;

    typedef enum logic [2:0] {
        BS_IDLE = 3'b000,
        BS_ADDR = 3'b001,
        BS_AACK = 3'b010,
        BS_WDATA = 3'b011,
        BS_WACK = 3'b100,
        BS_RDATA = 3'b101,
        BS_RACK = 3'b110
    } tscc_bus_type;

endpackage : tscc_pkg

// >>> sim/tscc_top_asserts.sv
// Concurrent checks on conversion timing and results of the sensor control.
`timescale 1ns/1ns
module tscc_top_asserts #(
    parameter int CONV_CYCLES_P = 4
) (
    input wire logic sys_clk_i, // System clock.
    input wire logic rst_n_i, // Reset, active low.
    input wire logic [11:0] local_raw_i, // Local raw result.
    input wire logic [11:0] remote_raw_i, // Remote raw result.
    input wire logic [7:0] remote_offset_trim_i, // Remote offset.
    input wire logic conv_start_o, // Start pulse.
    input wire logic busy_o, // Converting.
    input wire logic result_valid_o, // Result pulse.
    input wire logic [11:0] local_result_o, // Local result.
    input wire logic [11:0] remote_result_o // Remote result.
);
    logic [31:0] busy_len_reg;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Counts how long the current conversion has been running.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_len_reg <= 32'h0;
        end else begin
            busy_len_reg <= busy_o ? busy_len_reg + 32'h1 : 32'h0;
        end
    end

    sequence s_busy_run;
        busy_o [*4];
    endsequence
    sequence s_conv_done;
        $fell(busy_o) ##0 result_valid_o;
    endsequence

    a_boot_start: assert property ($rose(rst_n_i) |=> conv_start_o)
        else $error("no conversion start after reset");
    a_start_busy: assert property (conv_start_o |-> busy_o && !$past(busy_o))
        else $error("start without busy rising");
    a_busy_hold: assert property (conv_start_o |-> s_busy_run)
        else $error("busy dropped early");
    a_start_gap: assert property (conv_start_o |=> (!conv_start_o) [*3])
        else $error("start inside a conversion");
    a_conv_len: assert property ($fell(busy_o) |-> busy_len_reg == 32'(CONV_CYCLES_P))
        else $error("conversion length wrong");
    a_end_valid: assert property ($fell(busy_o) |-> result_valid_o)
        else $error("conversion ended without results");
    a_valid_at_end: assert property (result_valid_o |-> s_conv_done)
        else $error("results outside conversion end");
    a_local_res: assert property (result_valid_o |-> local_result_o == local_raw_i)
        else $error("local result wrong");
    a_remote_offset: assert property (result_valid_o |->
        remote_result_o == remote_raw_i + {remote_offset_trim_i, 4'h0})
        else $error("remote offset not applied");
endmodule : tscc_top_asserts

// >>> sim/tscc_host_model.sv
// Two-wire bus controller model that reaches the sensor's registers.
`timescale 1ns/1ns
module tscc_host_model (
    input wire logic clk_i, // Bench system clock.
    input wire logic sda_line_i, // Resolved data line.
    output logic scl_o, // Bus clock, held high between frames.
    output logic sda_o // Data drive, 1 lets the pull-up win.
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // Each bus clock phase lasts four system clocks, a 160 ns bus period.
    task automatic bit_io(input logic b, output logic s);
        @(posedge clk_i);
        sda_o <= b;
        repeat (3) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        s = sda_line_i;
        scl_o <= 1'b0;
    endtask : bit_io

    task automatic frame_edge(input logic a, input logic b);
        @(posedge clk_i);
        sda_o <= a;
        repeat (3) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        sda_o <= b;
        repeat (4) @(posedge clk_i);
    endtask : frame_edge

    task automatic tx_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask : tx_byte

    task automatic send2(input logic [7:0] a, input logic [7:0] b, output logic ok);
        logic a0;
        logic a1;
        frame_edge(1'b1, 1'b0);
        scl_o <= 1'b0;
        tx_byte(a, a0);
        tx_byte(b, a1);
        frame_edge(1'b0, 1'b1);
        ok = a0 & a1;
    endtask : send2

    task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ptr,
                          input logic [7:0] data, output logic ok);
        logic a0;
        logic a1;
        logic a2;
        frame_edge(1'b1, 1'b0);
        scl_o <= 1'b0;
        tx_byte({dev, 1'b0}, a0);
        tx_byte(ptr, a1);
        tx_byte(data, a2);
        frame_edge(1'b0, 1'b1);
        ok = a0 & a1 & a2;
    endtask : wr_reg

    task automatic rd_reg(input logic [6:0] dev, input logic [7:0] ptr,
                          output logic [7:0] data, output logic ok);
        logic a0;
        logic a1;
        logic s;
        send2({dev, 1'b0}, ptr, a0);
        frame_edge(1'b1, 1'b0);
        scl_o <= 1'b0;
        tx_byte({dev, 1'b1}, a1);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            data[i] = s;
        end
        bit_io(1'b1, s);
        frame_edge(1'b0, 1'b1);
        ok = a0 & a1;
    endtask : rd_reg
endmodule : tscc_host_model

// >>> sim/tb_tscc_top.sv
// Bench for the sensor conversion control with a two-wire host model.
`timescale 1ns/1ns
module tb_tscc_top;
    import tscc_pkg::*;
    localparam int RATE_P = 8;
    localparam int CONV_P = 4;
    localparam logic [6:0] ADDR = 7'h4C;
    // Arbitrary identification value.
    localparam logic [7:0] MAKER = 8'h3C;

    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic scl, sda_host, sda_dut, sda_oe_n, sda_line;
    logic alert = 1'b0;
    logic ot = 1'b0;
    logic [11:0] local_raw = 12'h0;
    logic [11:0] remote_raw = 12'h0;
    logic [7:0] trim = 8'h0;
    logic multi_n, conv_start, busy, valid, range_ext;
    logic [11:0] lres, rres;
    logic [7:0] ideal_adj;
    logic [31:0] seed = 32'h30;
    logic [31:0] gap_cnt = 32'h0;
    logic [31:0] last_gap = 32'h0;
    int n_starts = 0;
    int n_mismatch = 0;
    int num_checks = 0;

    assign sda_line = sda_host & (sda_oe_n | sda_dut);
    always #10 sys_clk_i = ~sys_clk_i;

    tscc_host_model u_host (.clk_i(sys_clk_i), .sda_line_i(sda_line), .scl_o(scl),
        .sda_o(sda_host));

    tscc_top #(.RATE_MIN_CYCLES_P(RATE_P), .CONV_CYCLES_P(CONV_P), .DEV_ADDR(ADDR),
        .MAKER_ID(MAKER)) u_dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_dut), .sda_oe_n_o(sda_oe_n), .alert_flag_i(alert),
        .second_overtemp_flag_i(ot), .local_raw_i(local_raw), .remote_raw_i(remote_raw),
        .remote_offset_trim_i(trim), .multi_out_n_o(multi_n), .conv_start_o(conv_start),
        .busy_o(busy), .result_valid_o(valid), .local_result_o(lres),
        .remote_result_o(rres), .range_ext_o(range_ext), .ideality_adj_o(ideal_adj));

    function automatic logic [31:0] next_rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : next_rnd

    function automatic logic [31:0] exp_gap(input logic [7:0] code);
        logic [7:0] c;
        c = (code > RATE_MAX_CODE) ? RATE_MAX_CODE : code;
        return 32'(RATE_P) << (8'h09 - c);
    endfunction : exp_gap

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
        logic ok;
        u_host.wr_reg(ADDR, ptr, data, ok);
        check(ok, 1'b1);
    endtask : wr

    task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
        logic ok;
        logic [7:0] d;
        u_host.rd_reg(ADDR, ptr, d, ok);
        check({ok, d}, {1'b1, exp});
    endtask : rd_chk

    task automatic wait_starts(input int n);
        int k;
        k = n_starts + n;
        for (int i = 0; i < 20000 && n_starts < k; i++) @(posedge sys_clk_i);
        check(n_starts >= k, 1'b1);
    endtask : wait_starts

    // New raw results arrive at each start so they hold still for the whole conversion.
    always @(posedge sys_clk_i) begin
        gap_cnt <= conv_start ? 32'h1 : gap_cnt + 32'h1;
        if (conv_start === 1'b1) begin
            last_gap <= gap_cnt;
            n_starts <= n_starts + 1;
            local_raw <= 12'(next_rnd());
            remote_raw <= 12'(next_rnd());
            trim <= 8'(next_rnd());
        end
    end

    initial begin
        repeat (80000) @(posedge sys_clk_i);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        logic [7:0] cfg;
        logic [7:0] codes [5];
        logic ok;
        int k;
        repeat (8) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        rd_chk(PTR_CFG_RD, CFG_RESET);
        rd_chk(PTR_RATE_RD, RATE_RESET);
        rd_chk(PTR_IDEAL, IDEAL_RESET);
        rd_chk(PTR_MAKER, MAKER);
        rd_chk(8'h77, READ_NONE);
        u_host.send2({ADDR ^ 7'h01, 1'b0}, PTR_CFG_RD, ok);
        check(ok, 1'b0);
        for (int i = 0; i < 4; i++) begin
            cfg = (8'(next_rnd()) & 8'h44) | {i[0], 1'b0, i[1], 5'h0};
            wr(PTR_CFG_WR, cfg);
            rd_chk(PTR_CFG_RD, cfg);
            check(range_ext, cfg[2]);
            repeat (3) begin
                alert <= 1'(next_rnd());
                ot <= 1'(next_rnd());
                repeat (2) @(posedge sys_clk_i);
                check(multi_n, {~(cfg[5] ? ot : alert & ~cfg[7])});
            end
        end
        wr(PTR_CFG_RD, 8'hFF);
        rd_chk(PTR_CFG_RD, cfg);
        wr(PTR_CFG_WR, 8'h00);
        codes = '{8'h09, 8'h0C, 8'h05, 8'h00, 8'(next_rnd()) & 8'h0F};
        foreach (codes[j]) begin
            wr(PTR_RATE_WR, codes[j]);
            rd_chk(PTR_RATE_RD, codes[j]);
            wait_starts(3);
            check(last_gap, exp_gap(codes[j]));
        end
        wr(PTR_RATE_WR, RATE_MAX_CODE);
        wr(PTR_CFG_WR, 8'h40);
        repeat (20) @(posedge sys_clk_i);
        k = n_starts;
        repeat (300) @(posedge sys_clk_i);
        check(n_starts - k, 0);
        wr(PTR_ONESHOT, 8'(next_rnd()));
        repeat (20) @(posedge sys_clk_i);
        check(n_starts - k, 1);
        rd_chk(PTR_CFG_RD, 8'h40);
        wr(PTR_CFG_WR, 8'h00);
        repeat (20) @(posedge sys_clk_i);
        check(n_starts > k + 1, 1'b1);
        codes = '{8'h80, 8'h7F, 8'(next_rnd()), 8'hFF, 8'h01};
        foreach (codes[j]) begin
            wr(PTR_IDEAL, codes[j]);
            rd_chk(PTR_IDEAL, codes[j]);
            check(ideal_adj, codes[j]);
        end
        wr(PTR_CFG_WR, 8'hE4);
        wr(PTR_RATE_WR, 8'h03);
        u_host.send2({GC_ADDR, 1'b0}, 8'h55, ok);
        check(ok, 1'b1);
        rd_chk(PTR_CFG_RD, 8'hE4);
        u_host.send2({GC_ADDR, 1'b0}, GC_RESET_CODE, ok);
        check(ok, 1'b1);
        rd_chk(PTR_CFG_RD, CFG_RESET);
        rd_chk(PTR_RATE_RD, RATE_RESET);
        rd_chk(PTR_IDEAL, IDEAL_RESET);
        end_of_test();
    end
endmodule : tb_tscc_top

bind tscc_top tscc_top_asserts #(.CONV_CYCLES_P(CONV_CYCLES_P)) u_chk (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .local_raw_i(local_raw_i),
    .remote_raw_i(remote_raw_i), .remote_offset_trim_i(remote_offset_trim_i),
    .conv_start_o(conv_start_o), .busy_o(busy_o), .result_valid_o(result_valid_o),
    .local_result_o(local_result_o), .remote_result_o(remote_result_o));
